// File: sel_defines.svh
// Timing and format constants for the serial echo link and its watchdog.
`ifndef SEL_DEFINES_SVH
`define SEL_DEFINES_SVH
`define SEL_CLK_MHZ 250
`define SEL_CHAR_W 8
`define SEL_STARTUP_MS 4000
`define SEL_STARTUP_CYC (`SEL_STARTUP_MS * 1000 * `SEL_CLK_MHZ)
`define SEL_WDOG_MS 660
`define SEL_WDOG_CYC (`SEL_WDOG_MS * 1000 * `SEL_CLK_MHZ)
`define SEL_PERIOD_MS 50
`define SEL_PERIOD_CYC (`SEL_PERIOD_MS * 1000 * `SEL_CLK_MHZ)
`define SEL_SCLK_KBPS 500
`define SEL_HALF_BIT_CYC (`SEL_CLK_MHZ * 1000 / (2 * `SEL_SCLK_KBPS))
`define SEL_ECHO_GAP_US 100
`define SEL_ECHO_GAP_CYC (`SEL_ECHO_GAP_US * `SEL_CLK_MHZ)
`define SEL_CHAR_RST 8'h00
`endif

// File: sel_pkg.sv
// Types shared by both ends of the serial echo link.
package sel_pkg;
  typedef logic [7:0] sel_char_t;
  typedef enum logic [1:0] {SEL_DEV_STARTUP, SEL_DEV_RUN} sel_dev_e;
  typedef enum logic [2:0] {SEL_HOST_WAIT, SEL_HOST_LO, SEL_HOST_HI, SEL_HOST_GAP,
                            SEL_HOST_CHECK} sel_host_e;
endpackage : sel_pkg

// File: sel_link_if.sv
// Serial link between the host master and the module controller.
interface sel_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso);
endinterface : sel_link_if

// File: sel_device.sv
// Module controller end: startup delay, echo of each character, watchdog restart.
// How it works
// - Ignore packets during the startup delay.
// - Activity output stays off during startup.
// - Watchdog disabled throughout startup delay.
// - Delay end enables watchdog and reception together.
// - Each received packet reloads the watchdog.
// - Over 660 ms without packets restarts controller.
// - Host sends one character every 50 ms.
// - Host character is previous plus one.
// - Host toggles send indicator per packet.
// - Activity output toggles on each packet.
// - Received character is echoed back unchanged.
// - Host toggles match indicator on correct echo.
`include "sel_defines.svh"
module sel_device #(
  parameter int unsigned STARTUP_CYC = `SEL_STARTUP_CYC,
  parameter int unsigned WDOG_CYC = `SEL_WDOG_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sel_link_if.device link,
  output logic rx_activity_out,
  output logic restart_pulse,
  output logic link_enabled
);
  import sel_pkg::*;

  initial begin
    if (STARTUP_CYC < 1 || WDOG_CYC < 1) begin
      $error("sel_device: counts must be at least one cycle");
    end
  end

  // Two-stage synchronisers for the link pins.
  logic [2:0] s1_q, s2_q, s3_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'b010;
      s2_q <= 3'b010;
      s3_q <= 3'b010;
    end else begin
      s1_q <= {link.mosi, link.cs_n, link.sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire sclk_rise = s2_q[0] & ~s3_q[0];
  wire sclk_fall = ~s2_q[0] & s3_q[0];
  wire cs_act = ~s2_q[1];
  wire cs_end = s2_q[1] & ~s3_q[1];

  // Controller state, timers, shift register and outputs.
  sel_dev_e st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d;
  logic [3:0] bits_q, bits_d;
  logic act_q, act_d, miso_q, miso_d, rst_q, rst_d;
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    rx_d = rx_q;
    tx_d = tx_q;
    bits_d = bits_q;
    act_d = act_q;
    miso_d = miso_q;
    rst_d = 1'b0;
    unique case (st_q)
      SEL_DEV_STARTUP: begin
        act_d = 1'b0;
        bits_d = 4'h0;
        if (tmr_q + 32'd1 >= STARTUP_CYC) begin
          st_d = SEL_DEV_RUN;
          tmr_d = 32'd0;
        end else begin
          tmr_d = tmr_q + 32'd1;
        end
      end
      SEL_DEV_RUN: begin
        tmr_d = tmr_q + 32'd1;
        if (!cs_act) begin
          bits_d = 4'h0;
          miso_d = tx_q[7];
        end else if (sclk_rise && bits_q < 4'd8) begin
          rx_d = {rx_q[6:0], s2_q[2]};
          bits_d = bits_q + 4'd1;
        end else if (sclk_fall && bits_q != 4'd0) begin
          tx_d = {tx_q[6:0], 1'b0};
          miso_d = tx_q[6];
        end
        if (cs_end && bits_q == 4'd8) begin
          tmr_d = 32'd0;
          act_d = ~act_q;
          tx_d = rx_q;
          miso_d = rx_q[7];
        end else if (tmr_q >= WDOG_CYC) begin
          st_d = SEL_DEV_STARTUP;
          tmr_d = 32'd0;
          act_d = 1'b0;
          tx_d = `SEL_CHAR_RST;
          miso_d = 1'b0;
          rst_d = 1'b1;
        end
      end
      default: begin
        st_d = SEL_DEV_STARTUP;
        tmr_d = 32'd0;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SEL_DEV_STARTUP;
      tmr_q <= 32'd0;
      rx_q <= `SEL_CHAR_RST;
      tx_q <= `SEL_CHAR_RST;
      bits_q <= 4'h0;
      act_q <= 1'b0;
      miso_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      bits_q <= bits_d;
      act_q <= act_d;
      miso_q <= miso_d;
      rst_q <= rst_d;
    end
  end

  // Outputs come straight from flip-flops.
  logic run_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= (st_d == SEL_DEV_RUN);
    end
  end
  assign link_enabled = run_q;
  assign rx_activity_out = act_q;
  assign restart_pulse = rst_q;
  assign link.miso = miso_q;
endmodule : sel_device

// File: sel_host.sv
// Host end: sends an incrementing character every period and checks the echo.
`include "sel_defines.svh"
module sel_host #(
  parameter int unsigned PERIOD_CYC = `SEL_PERIOD_CYC,
  parameter int unsigned HALF_BIT_CYC = `SEL_HALF_BIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sel_link_if.host link,
  output logic host_send_indicator,
  output logic host_match_indicator
);
  import sel_pkg::*;

  initial begin
    if (HALF_BIT_CYC < 2 || HALF_BIT_CYC > 65535 || PERIOD_CYC < 40 * HALF_BIT_CYC) begin
      $error("sel_host: period too short for one character");
    end
  end

  // Synchroniser for the returning data pin.
  logic mi1_q, mi2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mi1_q <= 1'b0;
      mi2_q <= 1'b0;
    end else begin
      mi1_q <= link.miso;
      mi2_q <= mi1_q;
    end
  end

  // Frame sequencer: each frame sends the next character and reads the prior echo.
  sel_host_e st_q, st_d;
  logic [31:0] per_q, per_d;
  logic [15:0] hb_q, hb_d;
  logic [3:0] bit_q, bit_d;
  sel_char_t tx_q, tx_d, rx_q, rx_d, exp_q, exp_d, sh_q, sh_d;
  logic sclk_q, sclk_d, cs_q, cs_d, snd_q, snd_d, mat_q, mat_d, got_q, got_d;
  always_comb begin
    st_d = st_q;
    per_d = (per_q + 32'd1 >= PERIOD_CYC) ? 32'd0 : per_q + 32'd1;
    hb_d = hb_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    exp_d = exp_q;
    sh_d = sh_q;
    sclk_d = sclk_q;
    cs_d = cs_q;
    snd_d = snd_q;
    mat_d = mat_q;
    got_d = got_q;
    unique case (st_q)
      SEL_HOST_WAIT: begin
        if (per_q == 32'd0) begin
          st_d = SEL_HOST_LO;
          cs_d = 1'b0;
          sh_d = tx_q;
          exp_d = tx_q - 8'd1;
          snd_d = ~snd_q;
          bit_d = 4'd0;
          hb_d = 16'd0;
        end
      end
      SEL_HOST_LO: begin
        hb_d = hb_q + 16'd1;
        if (hb_q + 16'd1 >= HALF_BIT_CYC[15:0]) begin
          hb_d = 16'd0;
          sclk_d = 1'b1;
          rx_d = {rx_q[6:0], mi2_q};
          st_d = SEL_HOST_HI;
        end
      end
      SEL_HOST_HI: begin
        hb_d = hb_q + 16'd1;
        if (hb_q + 16'd1 >= HALF_BIT_CYC[15:0]) begin
          hb_d = 16'd0;
          sclk_d = 1'b0;
          sh_d = {sh_q[6:0], 1'b0};
          bit_d = bit_q + 4'd1;
          st_d = (bit_q == 4'd7) ? SEL_HOST_GAP : SEL_HOST_LO;
        end
      end
      SEL_HOST_GAP: begin
        hb_d = hb_q + 16'd1;
        if (hb_q + 16'd1 >= HALF_BIT_CYC[15:0]) begin
          cs_d = 1'b1;
          st_d = SEL_HOST_CHECK;
        end
      end
      SEL_HOST_CHECK: begin
        if (got_q && rx_q == exp_q) begin
          mat_d = ~mat_q;
        end
        got_d = 1'b1;
        tx_d = tx_q + 8'd1;
        st_d = SEL_HOST_WAIT;
      end
      default: st_d = SEL_HOST_WAIT;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SEL_HOST_WAIT;
      per_q <= 32'd1;
      hb_q <= 16'd0;
      bit_q <= 4'd0;
      tx_q <= `SEL_CHAR_RST;
      rx_q <= `SEL_CHAR_RST;
      exp_q <= `SEL_CHAR_RST;
      sh_q <= `SEL_CHAR_RST;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      snd_q <= 1'b0;
      mat_q <= 1'b0;
      got_q <= 1'b0;
    end else begin
      st_q <= st_d;
      per_q <= per_d;
      hb_q <= hb_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      exp_q <= exp_d;
      sh_q <= sh_d;
      sclk_q <= sclk_d;
      cs_q <= cs_d;
      snd_q <= snd_d;
      mat_q <= mat_d;
      got_q <= got_d;
    end
  end

  // Pin and indicator drive.
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.mosi = sh_q[7];
  assign host_send_indicator = snd_q;
  assign host_match_indicator = mat_q;
endmodule : sel_host

// File: sel_link_monitor.sv
// Concurrent checks on the serial echo link and the controller outputs beside it.
module sel_link_monitor #(
  parameter int unsigned WDOG_CYC = 3000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rx_activity_out,
  input wire logic restart_pulse,
  input wire logic link_enabled
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclk_q;
  logic en_q;
  logic [3:0] bits_q;
  int unsigned idle_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Counts clock rises per frame, keeps the enable seen before the frame, times silence.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      en_q <= 1'b0;
      bits_q <= 4'h0;
      idle_q <= 0;
    end else begin
      sclk_q <= sclk;
      bits_q <= cs_n ? 4'h0 : bits_q + 4'(sclk && !sclk_q);
      en_q <= cs_n ? link_enabled : en_q;
      idle_q <= (!link_enabled || $changed(rx_activity_out)) ? 0 : idle_q + 1;
    end
  end
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low outside a frame");
  a_mosi_held_high: assert property (sclk && sclk_q |-> $stable(mosi))
    else $error("host data moved while serial clock high");
  a_eight_bit_frame: assert property ($rose(cs_n) |-> bits_q == 4'h8)
    else $error("frame did not carry eight clocks");
  a_startup_dark: assert property (!link_enabled |-> !rx_activity_out)
    else $error("activity output lit during startup");
  a_packet_toggles: assert property ($rose(cs_n) && en_q |-> ##[1:6] $changed(rx_activity_out))
    else $error("accepted packet did not toggle activity");
  a_restart_clears: assert property (restart_pulse |-> ##2 !link_enabled && !rx_activity_out)
    else $error("restart did not re-enter startup");
  a_no_early_restart: assert property (restart_pulse |-> $past(link_enabled) && idle_q >= WDOG_CYC - 8)
    else $error("restart came too early");
  a_watchdog_bound: assert property (link_enabled |-> idle_q <= WDOG_CYC + 8)
    else $error("watchdog failed to expire");
  a_enable_drop: assert property ($fell(link_enabled) |-> restart_pulse || $past(restart_pulse))
    else $error("enable fell without a restart");
endmodule : sel_link_monitor

// File: spi_echo_link_watchdog_bench.sv
// Bench: a host and controller pair, plus a controller driven by the bench itself.
module spi_echo_link_watchdog_bench import sel_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SU = 2000;
  localparam int WD = 3000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic act_a, rp_a, en_a, act_b, rp_b, en_b, mat, m_q = 1'b0, snd, s_q = 1'b0;
  int error_cnt = 0, samples_checked = 0, m_n = 0, r_n = 0, s_n = 0;
  sel_link_if la ();
  sel_link_if lb ();
  sel_device #(.STARTUP_CYC(SU), .WDOG_CYC(WD)) sel_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(la), .rx_activity_out(act_a), .restart_pulse(rp_a), .link_enabled(en_a));
  sel_host #(.PERIOD_CYC(400), .HALF_BIT_CYC(10)) sel_host_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(la), .host_send_indicator(snd), .host_match_indicator(mat));
  sel_device #(.STARTUP_CYC(SU), .WDOG_CYC(WD)) sel_device_x_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(lb), .rx_activity_out(act_b), .restart_pulse(rp_b), .link_enabled(en_b));
  sel_link_monitor #(.WDOG_CYC(WD)) sel_link_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .sclk(la.sclk), .cs_n(la.cs_n), .mosi(la.mosi), .miso(la.miso), .rx_activity_out(act_a),
    .restart_pulse(rp_a), .link_enabled(en_a));
  // Clock of 4 ns period.
  always #2 ref_clk = ~ref_clk;
  // Counts match toggles and restarts of the pair.
  always @(posedge ref_clk) begin
    if (mat !== m_q) m_n++;
    m_q <= mat;
    if (snd !== s_q) s_n++;
    s_q <= snd;
    if (rp_a === 1'b1) r_n++;
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task results();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // One frame of 80 ns clock periods; the echo bit is taken at each rise.
  task xfer(input sel_char_t t, output sel_char_t r);
    lb.cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      lb.mosi = t[i];
      tick(10);
      lb.sclk = 1'b1;
      r[i] = lb.miso;
      tick(10);
      lb.sclk = 1'b0;
    end
    tick(10);
    lb.cs_n = 1'b1;
    lb.mosi = ~lb.mosi;
    tick(20);
  endtask : xfer
  // Bounded wait for a level on a controller output.
  task automatic hold(ref logic s, input int lim, output int k);
    for (k = 0; k < lim && s !== 1'b1; k++) tick(1);
    if (s !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask : hold
  initial begin
    sel_char_t tx, rx, prev;
    int k;
    void'($urandom(96300));
    lb.cs_n = 1'b1;
    lb.sclk = 1'b0;
    lb.mosi = 1'b0;
    #1 rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    xfer(8'hA5, rx);
    chk("startup activity", 8'h00, 8'(act_b));
    chk("startup enable", 8'h00, 8'(en_b));
    hold(en_b, SU, k);
    chk("activity at enable", 8'h00, 8'(act_b));
    $display("test startup done");
    prev = 8'h00;
    for (int i = 0; i < 8; i++) begin
      tx = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      xfer(tx, rx);
      chk("activity", 8'((i + 1) % 2), 8'(act_b));
      if (i > 0) chk("echo", prev, rx);
      prev = tx;
    end
    $display("test echo done");
    hold(rp_b, WD + 100, k);
    chk("watchdog wait", 8'h01, 8'(k >= WD - 60));
    tick(3);
    chk("restart enable", 8'h00, 8'(en_b | act_b));
    hold(en_b, SU + 50, k);
    chk("second startup", 8'h01, 8'(k >= SU - 10));
    $display("test watchdog done");
    chk("pair restarts", 8'h00, 8'(r_n));
    chk("pair matches", 8'h01, 8'(m_n >= 5));
    chk("pair sends", 8'h01, 8'(s_n > m_n));
    $display("test pair done");
    results();
  end
endmodule : spi_echo_link_watchdog_bench
